//--- verilog/ldm_monitor.sv
// Load diagnosis monitor: error latch, output monitor, open-load checks.
// Assumes comparator results arrive synchronous to i_core_clk.
//
// Behaviour
// - Fault sets error flag and latches channel off; write 1 to clear bit.
// - Error flag and latch state is held per channel, independent of others.
// - Monitor bit is low-side Vds low or high-side Vout high; read refreshes.
// - Each channel has its own off-state current enable bit.
// - Open load seen by the monitor never latches the channel off.
// - Off-state summary is OR of monitor bits of off, current-enabled channels.
// - On-state result is low current with high output, high-side channels only.
// - After reset on-state checking stays inactive until selection is written.
// - Selection 0010 to 0111 routes mux to that channel; valid after settle.
// - Single mode clears other result bits; result register refreshed on read.
// - Single mode mirrors selected result into summary at standard readout.
// - Selection 1010 starts an autonomous loop over eligible channels.
// - Loop checks direct channels from 2; settle+sync, then switch+sync.
// - Direct channel off at its check gets result 0.
// - Then PWM channels, generator 0 first, on switch-on edge, maxon+switch.
// - Off PWM channel waits next on phase; too short on phase gives 0.
// - Loop end sets selection to 1111; results hold until next loop or a single-mode result read.
// - At 1010 summary is live OR of results; at 1111 the last loop's OR.
// - Reserved selection values give summary 0; controller avoids them.
// - Maximum-on wait lies between 40 and 76 us, nominally 58 us.
// - Settle time at most 40 us, switching time at most 20 us.
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ldm_monitor (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic [7:0] i_fault,
    input wire logic [7:0] i_vds_low,
    input wire logic [7:0] i_vout_high,
    input wire logic [7:0] i_il_low,
    input wire logic [1:0] i_pwm_gen,
    output logic [7:0] o_ch_on,
    output logic [7:0] o_iol_en,
    output logic [7:0] o_err,
    output logic [2:0] o_mux_sel,
    output logic o_mux_en
);

    typedef struct packed {
        logic [7:0] ch_on_req;
        logic [7:0] pwm_map;
        logic [7:0] pwm_gen;
        logic [7:0] hs_use;
        logic [7:0] iol;
        logic [7:0] err;
        logic [7:0] latch;
        logic [7:0] osm;
        logic [7:0] onstate_open_summary;
        logic [7:0] on;
        logic [7:0] on_prev;
        logic [3:0] sel;
        ldm_pkg::ldm_loop_type fsm;
        logic [4:0] pos;
        logic [2:0] ch;
        logic first_dir;
        logic first_pwm;
        logic [11:0] cnt;
        logic [31:0] rdata;
    } ldm_mon_state_type;

    ldm_mon_state_type q;
    ldm_mon_state_type next_q;
    ldm_pkg::ldm_req_type req;
    logic rst_meta;
    logic rst_n;
    logic [7:0] mon;
    logic [7:0] res;
    logic [7:0] drive;
    logic single;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // Bus front end
    // ----------------------------------------------------------------
    ldm_ahb_if u_ahb (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_hsel(i_hsel),
        .i_haddr(i_haddr),
        .i_htrans(i_htrans),
        .i_hwrite(i_hwrite),
        .i_hready(i_hready),
        .o_req(req)
    );

    // ----------------------------------------------------------------
    // Per-channel comparisons
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < ldm_pkg::N_CH; gi = gi + 1) begin : g_ch
            assign mon[gi] = q.hs_use[gi] ? i_vout_high[gi] : i_vds_low[gi];
            assign res[gi] = ldm_pkg::HS_CAPABLE[gi] & q.hs_use[gi]
                & i_il_low[gi] & i_vout_high[gi];
            assign drive[gi] = q.pwm_map[gi] ? i_pwm_gen[q.pwm_gen[gi]]
                : q.ch_on_req[gi];
        end
    endgenerate

    assign single = (q.sel >= ldm_pkg::SEL_FIRST) && (q.sel <= ldm_pkg::SEL_LAST);

    // ----------------------------------------------------------------
    // Loop order: direct, then generator 0, then generator 1
    // ----------------------------------------------------------------
    function automatic logic pos_ok(input logic [4:0] p, input logic [7:0] hs,
                                    input logic [7:0] pm, input logic [7:0] pg);
        logic [2:0] c;
        logic ok;
        c = 3'(p % ldm_pkg::POS_PER_PHASE + 5'h02);
        ok = ldm_pkg::HS_CAPABLE[c] & hs[c];
        if (p < ldm_pkg::POS_PER_PHASE) begin
            pos_ok = ok & ~pm[c];
        end else if (p < 5'(2 * ldm_pkg::POS_PER_PHASE)) begin
            pos_ok = ok & pm[c] & ~pg[c];
        end else begin
            pos_ok = ok & pm[c] & pg[c];
        end
    endfunction : pos_ok

    function automatic logic [4:0] pos_next(input logic [4:0] from, input logic [7:0] hs,
                                            input logic [7:0] pm, input logic [7:0] pg);
        logic [4:0] r;
        r = ldm_pkg::POS_NONE;
        for (int k = int'(ldm_pkg::POS_COUNT) - 1; k >= 0; k--) begin
            if ((from == ldm_pkg::POS_NONE || 5'(k) > from) && pos_ok(5'(k), hs, pm, pg)) begin
                r = 5'(k);
            end
        end
        pos_next = r;
    endfunction : pos_next

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [4:0] np;
        logic adv;
        logic [7:0] clr;
        logic [7:0] one;
        logic onstate_open_summary_sum;
        np = ldm_pkg::POS_NONE;
        adv = 1'b0;
        clr = 8'h00;
        one = 8'h00;
        onstate_open_summary_sum = 1'b0;
        next_q = q;
        if (q.cnt != 12'h000) begin
            next_q.cnt = q.cnt - 12'h001;
        end
        // Register writes
        if (req.wr) begin
            unique case (req.wr_addr)
                ldm_pkg::OFS_CH_ON: next_q.ch_on_req = i_hwdata[7:0];
                ldm_pkg::OFS_PWM_MAP: begin
                    next_q.pwm_map = i_hwdata[7:0];
                    next_q.pwm_gen = i_hwdata[ldm_pkg::PWM_GEN_LSB +: 8];
                end
                ldm_pkg::OFS_HS_USE: next_q.hs_use = i_hwdata[7:0];
                ldm_pkg::OFS_CURRENT_EN: next_q.iol = i_hwdata[7:0];
                ldm_pkg::OFS_LATCH_CLR: clr = i_hwdata[7:0];
                ldm_pkg::OFS_CHECK_SEL: begin
                    next_q.sel = i_hwdata[3:0];
                    next_q.fsm = ldm_pkg::LS_IDLE;
                    next_q.ch = i_hwdata[2:0];
                    next_q.cnt = ldm_pkg::SETTLE_CYC;
                    if (i_hwdata[3:0] == ldm_pkg::SEL_LOOP) begin
                        next_q.onstate_open_summary = 8'h00;
                        next_q.first_dir = 1'b1;
                        next_q.first_pwm = 1'b1;
                        next_q.pos = ldm_pkg::POS_NONE;
                        adv = 1'b1;
                    end else if (i_hwdata[3:0] < ldm_pkg::SEL_FIRST
                                 || i_hwdata[3:0] > ldm_pkg::SEL_LAST) begin
                        next_q.cnt = 12'h000;
                    end
                end
                default: begin
                end
            endcase
        end
        // Error flag and latch, set wins over clear, per channel
        next_q.err = (q.err & ~clr) | i_fault;
        next_q.latch = (q.latch & ~clr) | i_fault;
        next_q.on = drive & ~next_q.latch;
        next_q.on_prev = q.on;
        // Autonomous loop
        unique case (q.fsm)
            ldm_pkg::LS_IDLE: begin
            end
            ldm_pkg::LS_DIR: begin
                if (q.cnt == 12'h000) begin
                    next_q.onstate_open_summary[q.ch] = q.on[q.ch] & res[q.ch];
                    adv = 1'b1;
                end
            end
            ldm_pkg::LS_PWM_SETTLE: begin
                if (q.cnt == 12'h000) begin
                    next_q.fsm = ldm_pkg::LS_PWM_WAIT;
                end
            end
            ldm_pkg::LS_PWM_WAIT: begin
                if (q.on[q.ch] && !q.on_prev[q.ch]) begin
                    next_q.fsm = ldm_pkg::LS_PWM_RUN;
                    next_q.cnt = ldm_pkg::MAXON_CYC + ldm_pkg::SWITCH_CYC;
                end
            end
            ldm_pkg::LS_PWM_RUN: begin
                if (!q.on[q.ch]) begin
                    next_q.onstate_open_summary[q.ch] = 1'b0;
                    adv = 1'b1;
                end else if (q.cnt == 12'h000) begin
                    next_q.onstate_open_summary[q.ch] = res[q.ch];
                    adv = 1'b1;
                end
            end
        endcase
        if (adv) begin
            np = pos_next(next_q.pos, next_q.hs_use, next_q.pwm_map, next_q.pwm_gen);
            next_q.pos = np;
            if (np == ldm_pkg::POS_NONE) begin
                next_q.fsm = ldm_pkg::LS_IDLE;
                next_q.sel = ldm_pkg::SEL_IDLE;
            end else begin
                next_q.ch = 3'(np % ldm_pkg::POS_PER_PHASE + 5'h02);
                if (np < ldm_pkg::POS_PER_PHASE) begin
                    next_q.fsm = ldm_pkg::LS_DIR;
                    next_q.cnt = (next_q.first_dir ? ldm_pkg::SETTLE_CYC
                        : ldm_pkg::SWITCH_CYC) + ldm_pkg::SYNC_CYC;
                    next_q.first_dir = 1'b0;
                end else if (next_q.first_pwm) begin
                    next_q.fsm = ldm_pkg::LS_PWM_SETTLE;
                    next_q.cnt = ldm_pkg::SETTLE_CYC;
                    next_q.first_pwm = 1'b0;
                end else begin
                    next_q.fsm = ldm_pkg::LS_PWM_WAIT;
                end
            end
        end
        // Single channel result, only valid after settling
        if (single && q.cnt == 12'h000) begin
            one[q.ch] = q.on[q.ch] & res[q.ch];
        end
        unique case (q.sel)
            ldm_pkg::SEL_LOOP, ldm_pkg::SEL_IDLE: onstate_open_summary_sum = |q.onstate_open_summary;
            default: onstate_open_summary_sum = single ? one[q.ch] : 1'b0;
        endcase
        // Register reads, refreshed at the read request
        next_q.rdata = 32'h0000_0000;
        if (req.rd) begin
            unique case (req.rd_addr)
                ldm_pkg::OFS_CH_ON: next_q.rdata[7:0] = q.ch_on_req;
                ldm_pkg::OFS_PWM_MAP: begin
                    next_q.rdata[7:0] = q.pwm_map;
                    next_q.rdata[ldm_pkg::PWM_GEN_LSB +: 8] = q.pwm_gen;
                end
                ldm_pkg::OFS_HS_USE: next_q.rdata[7:0] = q.hs_use;
                ldm_pkg::OFS_CURRENT_EN: next_q.rdata[7:0] = q.iol;
                ldm_pkg::OFS_ERROR: next_q.rdata[7:0] = q.err;
                ldm_pkg::OFS_MONITOR: begin
                    next_q.osm = mon;
                    next_q.rdata[7:0] = mon;
                end
                ldm_pkg::OFS_CHECK_SEL: next_q.rdata[3:0] = q.sel;
                ldm_pkg::OFS_ONSTATE: begin
                    if (single) begin
                        next_q.onstate_open_summary = one;
                        next_q.rdata[7:0] = one;
                    end else begin
                        next_q.rdata[7:0] = q.onstate_open_summary;
                    end
                end
                ldm_pkg::OFS_STD_DIAG: begin
                    next_q.rdata[ldm_pkg::STD_OFFSTATE_OPEN_SUMMARY_BIT] = |(mon & ~q.on & q.iol);
                    next_q.rdata[ldm_pkg::STD_ONSTATE_OPEN_SUMMARY_BIT] = onstate_open_summary_sum;
                    next_q.rdata[ldm_pkg::STD_BUSY_BIT] = q.fsm != ldm_pkg::LS_IDLE;
                    next_q.rdata[ldm_pkg::STD_ERR_LSB +: 8] = q.err;
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.sel <= ldm_pkg::SEL_IDLE;
            q.fsm <= ldm_pkg::LS_IDLE;
            q.pos <= ldm_pkg::POS_NONE;
        end else begin
            q <= next_q;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = q.rdata;
    assign o_ch_on = q.on;
    assign o_iol_en = q.iol;
    assign o_err = q.err;
    assign o_mux_sel = q.ch;
    assign o_mux_en = (q.fsm != ldm_pkg::LS_IDLE) || single;

endmodule : ldm_monitor
`default_nettype wire

//--- verilog/ldm_pkg.sv
// Shared constants and types for the load diagnosis monitor.
// Assumes a 40 MHz core clock and an AHB-Lite register bus.
package ldm_pkg;

    // ----------------------------------------------------------------
    // Geometry and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int N_CH = 8;
    localparam int SETTLE_US = 40;
    localparam int SWITCH_US = 20;
    localparam int MAXON_US = 58;
    localparam int MONITOR_SETTLE_US = 20;
    localparam logic [11:0] SETTLE_CYC = 12'(SETTLE_US * CLK_MHZ);
    localparam logic [11:0] SWITCH_CYC = 12'(SWITCH_US * CLK_MHZ);
    localparam logic [11:0] MAXON_CYC = 12'(MAXON_US * CLK_MHZ);
    localparam logic [11:0] SYNC_CYC = 12'h004;
    localparam logic [7:0] HS_CAPABLE = 8'hFC;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CH_ON = 8'h00;
    localparam logic [7:0] OFS_PWM_MAP = 8'h04;
    localparam logic [7:0] OFS_HS_USE = 8'h08;
    localparam logic [7:0] OFS_CURRENT_EN = 8'h0C;
    localparam logic [7:0] OFS_LATCH_CLR = 8'h10;
    localparam logic [7:0] OFS_ERROR = 8'h14;
    localparam logic [7:0] OFS_MONITOR = 8'h18;
    localparam logic [7:0] OFS_CHECK_SEL = 8'h1C;
    localparam logic [7:0] OFS_ONSTATE = 8'h20;
    localparam logic [7:0] OFS_STD_DIAG = 8'h24;

    // ----------------------------------------------------------------
    // Field positions and codes
    // ----------------------------------------------------------------
    localparam int STD_OFFSTATE_OPEN_SUMMARY_BIT = 0;
    localparam int STD_ONSTATE_OPEN_SUMMARY_BIT = 1;
    localparam int STD_BUSY_BIT = 2;
    localparam int STD_ERR_LSB = 8;
    localparam int PWM_GEN_LSB = 8;
    localparam logic [3:0] SEL_LOOP = 4'hA;
    localparam logic [3:0] SEL_IDLE = 4'hF;
    localparam logic [3:0] SEL_FIRST = 4'h2;
    localparam logic [3:0] SEL_LAST = 4'h7;
    localparam logic [4:0] POS_NONE = 5'h1F;
    localparam logic [4:0] POS_COUNT = 5'h12;
    localparam logic [4:0] POS_PER_PHASE = 5'h06;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        LS_IDLE, LS_DIR, LS_PWM_SETTLE, LS_PWM_WAIT, LS_PWM_RUN
    } ldm_loop_type;

    typedef struct packed {
        logic rd;
        logic [7:0] rd_addr;
        logic wr;
        logic [7:0] wr_addr;
    } ldm_req_type;

endpackage : ldm_pkg

//--- verilog/ldm_ahb_if.sv
// AHB-Lite slave front end: turns bus phases into read and write strobes.
// Assumes a single slave, zero wait states and word transfers only.
`timescale 1ns/1ps
`default_nettype none
module ldm_ahb_if (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    output ldm_pkg::ldm_req_type o_req
);

    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
    } ldm_ahb_state_type;

    ldm_ahb_state_type q;
    ldm_ahb_state_type next_q;
    logic take;

    // ----------------------------------------------------------------
    // Address phase acceptance
    // ----------------------------------------------------------------
    assign take = i_hsel && i_hready && (i_htrans == ldm_pkg::HTRANS_NONSEQ);

    always_comb begin
        next_q = q;
        next_q.wr_pend = take && i_hwrite;
        if (take) begin
            next_q.wr_addr = i_haddr[7:0];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign o_req.rd = take && !i_hwrite;
    assign o_req.rd_addr = i_haddr[7:0];
    assign o_req.wr = q.wr_pend;
    assign o_req.wr_addr = q.wr_addr;

endmodule : ldm_ahb_if
`default_nettype wire

//--- bench/ldm_monitor_props.sv
// Checker for the load diagnosis monitor, bound to its top ports.
// Assumes zero-wait AHB-Lite and a two-flop reset release.
`timescale 1ns/1ps
`default_nettype none
module ldm_monitor_props (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic [7:0] i_fault,
    input wire logic [7:0] o_ch_on,
    input wire logic [7:0] o_iol_en,
    input wire logic [7:0] o_err,
    input wire logic [2:0] o_mux_sel,
    input wire logic o_mux_en
);
    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    logic wr_ph;
    logic wr_iol;
    logic wr_clr;
    logic [1:0] rel_cnt;
    logic sel_seen;
    assign wr_ph = i_hsel && i_hready && i_htrans == 2'h2 && i_hwrite;
    assign wr_iol = wr_ph && i_haddr[7:0] == 8'h0C;
    assign wr_clr = wr_ph && i_haddr[7:0] == 8'h10;
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rel_cnt <= 2'h0;
            sel_seen <= 1'b0;
        end else begin
            if (rel_cnt != 2'h3) begin
                rel_cnt <= rel_cnt + 2'h1;
            end
            if (wr_ph && i_haddr[7:0] == 8'h1C) begin
                sel_seen <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_fault_err;
        rel_cnt == 2'h3 |=> (o_err & $past(i_fault)) == $past(i_fault);
    endproperty
    a_fault_err: assert property (p_fault_err) else $error("fault did not set flag");
    property p_fault_off;
        rel_cnt == 2'h3 && i_fault != 8'h00 |-> ##1 (o_ch_on & $past(i_fault)) == 8'h00;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("faulty channel stayed on");
    property p_err_off;
        (o_ch_on & o_err) == 8'h00;
    endproperty
    a_err_off: assert property (p_err_off) else $error("flagged channel is on");
    property p_err_indep;
        (o_err & ~$past(o_err) & ~$past(i_fault)) == 8'h00;
    endproperty
    a_err_indep: assert property (p_err_indep) else $error("flag set without fault");
    property p_err_clear;
        ($past(o_err) & ~o_err) != 8'h00 |-> $past(wr_clr, 2);
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("flag fell without clear");
    property p_iol_write;
        $changed(o_iol_en) |-> $past(wr_iol, 2);
    endproperty
    a_iol_write: assert property (p_iol_write) else $error("current enable moved alone");
    property p_mux_range;
        o_mux_en |-> o_mux_sel >= 3'h2;
    endproperty
    a_mux_range: assert property (p_mux_range) else $error("mux on bad channel");
    property p_mux_idle;
        !sel_seen |-> !o_mux_en;
    endproperty
    a_mux_idle: assert property (p_mux_idle) else $error("mux active before select");
endmodule : ldm_monitor_props
`default_nettype wire

//--- bench/ldm_host.sv
// Controller model: AHB-Lite master issuing single word transfers.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none
module ldm_host (
    input wire logic i_core_clk,
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    output logic o_hsel,
    output logic [31:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [2:0] o_hsize,
    output logic [31:0] o_hwdata
);
    initial begin
        o_hsel = 1'b0;
        o_haddr = 32'h0;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize = 3'h2;
        o_hwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge i_core_clk);
        o_hsel <= 1'b1;
        o_haddr <= {24'h000000, a};
        o_htrans <= 2'h2;
        o_hwrite <= w;
        do @(posedge i_core_clk); while (i_hready !== 1'b1);
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        o_hwdata <= d;
        do @(posedge i_core_clk); while (i_hready !== 1'b1);
        q = i_hrdata;
    endtask : xfer
    // Monitor settling wait before trusting monitor bits
    task automatic settle;
        repeat (ldm_pkg::MONITOR_SETTLE_US * ldm_pkg::CLK_MHZ) @(posedge i_core_clk);
    endtask : settle
endmodule : ldm_host
`default_nettype wire

//--- bench/tb_load_diagnosis_monitor.sv
// Self-checking bench for the load diagnosis monitor.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_load_diagnosis_monitor;
    logic core_clk = 1'b0;
    logic arst_n, hsel, hwrite, hready, hresp, mux_en;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [1:0] pwm_gen = 2'h0;
    logic [2:0] hsize, mux_sel;
    logic [7:0] fault, vds_low, vout_high, il_low, ch_on, iol_en, err;
    int error_cnt = 0;
    int n_checks = 0;
    always #12.5 core_clk = ~core_clk;
    ldm_host u_host (.i_core_clk(core_clk), .i_hready(hready), .i_hrdata(hrdata),
        .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
        .o_hsize(hsize), .o_hwdata(hwdata));
    ldm_monitor dut (.i_core_clk(core_clk), .i_arst_n(arst_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
        .o_hrdata(hrdata), .i_fault(fault), .i_vds_low(vds_low),
        .i_vout_high(vout_high), .i_il_low(il_low), .i_pwm_gen(pwm_gen),
        .o_ch_on(ch_on), .o_iol_en(iol_en), .o_err(err), .o_mux_sel(mux_sel),
        .o_mux_en(mux_en));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        u_host.xfer(1'b0, a, 32'h0, q);
        chk($sformatf("reg %h", a), e, q);
    endtask : rc
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    always begin
        repeat (4000) @(posedge core_clk);
        pwm_gen <= 2'h2;
        repeat (1000) @(posedge core_clk);
        pwm_gen <= 2'h1;
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        conclude();
    end
    initial begin
        arst_n = 1'b0;
        fault = 8'h00;
        vds_low = 8'h00;
        vout_high = 8'h00;
        il_low = 8'h00;
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rc(8'h1C, 32'hF);
        rc(8'h20, 32'h0);
        rc(8'h24, 32'h0);
        rc(8'h10, 32'h0);
        rc(8'h3C, 32'h0);
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("mux_en", 32'h0, {31'h0, mux_en});
        $display("test reset done");
        wr(8'h08, 32'hFC);
        wr(8'h00, 32'hFF);
        @(posedge core_clk) fault <= 8'h08;
        @(posedge core_clk) fault <= 8'h00;
        repeat (2) @(posedge core_clk);
        chk("err", 32'h08, {24'h0, err});
        chk("ch_on", 32'hF7, {24'h0, ch_on});
        rc(8'h14, 32'h08);
        wr(8'h10, 32'h08);
        repeat (3) @(posedge core_clk);
        chk("ch_on", 32'hFF, {24'h0, ch_on});
        rc(8'h14, 32'h0);
        $display("test fault done");
        wr(8'h00, 32'h0F);
        wr(8'h0C, 32'h30);
        vds_low <= 8'h03;
        vout_high <= 8'hA0;
        u_host.settle();
        chk("iol", 32'h30, {24'h0, iol_en});
        rc(8'h18, 32'hA3);
        rc(8'h24, 32'h1);
        wr(8'h0C, 32'h10);
        rc(8'h24, 32'h0);
        chk("ch_on", 32'h0F, {24'h0, ch_on});
        rc(8'h14, 32'h0);
        $display("test monitor done");
        wr(8'h00, 32'hFF);
        vds_low <= 8'h00;
        vout_high <= 8'h0C;
        il_low <= 8'h08;
        repeat (1600) @(posedge core_clk);
        wr(8'h1C, 32'h3);
        rc(8'h20, 32'h0);
        chk("mux", 32'h3, {29'h0, mux_sel});
        chk("mux_en", 32'h1, {31'h0, mux_en});
        repeat (1600) @(posedge core_clk);
        rc(8'h20, 32'h08);
        rc(8'h24, 32'h2);
        wr(8'h1C, 32'hB);
        rc(8'h24, 32'h0);
        wr(8'h1C, 32'h2);
        repeat (1600) @(posedge core_clk);
        rc(8'h20, 32'h0);
        $display("test single done");
        wr(8'h00, 32'hF7);
        wr(8'h08, 32'hEC);
        il_low <= 8'h38;
        vout_high <= 8'h3C;
        wr(8'h1C, 32'hA);
        repeat (1700) @(posedge core_clk);
        chk("mux", 32'h3, {29'h0, mux_sel});
        rc(8'h24, 32'h4);
        repeat (3300) @(posedge core_clk);
        rc(8'h1C, 32'hF);
        rc(8'h20, 32'h20);
        rc(8'h24, 32'h2);
        il_low <= 8'h00;
        rc(8'h20, 32'h20);
        $display("test loop done");
        wr(8'h04, 32'h40C0);
        wr(8'h00, 32'h00);
        il_low <= 8'hC0;
        vout_high <= 8'hC0;
        wr(8'h1C, 32'hA);
        q = 32'h0;
        for (int i = 0; i < 60 && q[3:0] !== 4'hF; i++) begin
            repeat (400) @(posedge core_clk);
            u_host.xfer(1'b0, 8'h1C, 32'h0, q);
        end
        rc(8'h20, 32'h80);
        $display("test pwm loop done");
        conclude();
    end
endmodule : tb_load_diagnosis_monitor
bind ldm_monitor ldm_monitor_props u_props (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hready(i_hready), .i_fault(i_fault), .o_ch_on(o_ch_on), .o_iol_en(o_iol_en),
    .o_err(o_err), .o_mux_sel(o_mux_sel), .o_mux_en(o_mux_en));
`default_nettype wire
